//--- rtl/lcs_storage_pair.sv
// storage pair of a logic cell with data, output and control steering
`timescale 1ns/10ps
module lcs_storage_pair (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [lcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lcs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic storage_clock,
  input wire logic global_init_pulse,
  input wire logic [lcs_pkg::CTL_N-1:0] general_control_inputs,
  input wire logic [lcs_pkg::LUT_FOUR_IN-1:0] lut_four_a_in,
  input wire logic [lcs_pkg::LUT_FOUR_IN-1:0] lut_four_b_in,
  output logic cell_q0,
  output logic cell_q1,
  output logic comb_x,
  output logic comb_y
);
  import lcs_pkg::*;

  localparam int unsigned TAB4 = 2**LUT_FOUR_IN;
  localparam int unsigned TAB3 = 2**LUT_THREE_IN;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // two-flop synchronisers for everything arriving from the fabric
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;

  assign pin_raw = {global_init_pulse, storage_clock, lut_four_b_in, lut_four_a_in, general_control_inputs};

  generate
    for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pin_raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  logic [CTL_N-1:0] ctl_s;
  logic [LUT_FOUR_IN-1:0] fa_s;
  logic [LUT_FOUR_IN-1:0] gb_s;
  logic clk_s;
  logic init_s;

  assign ctl_s = sync_q[SY_CTL +: CTL_N];
  assign fa_s = sync_q[SY_FA +: LUT_FOUR_IN];
  assign gb_s = sync_q[SY_GB +: LUT_FOUR_IN];
  assign clk_s = sync_q[SY_CLK];
  assign init_s = sync_q[SY_INIT];

  // configuration register and register port
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic wr_lut_a, wr_lut_b, wr_lut_h;
  logic [TAB4-1:0] tab_a, tab_b;
  logic [TAB3-1:0] tab_h;
  logic lut_a_q, lut_b_q, lut_h_q;
  logic [1:0] q_q, q_d;
  logic x_q, x_d, y_q, y_d;
  logic clk_prev_q;

  always_comb begin
    cfg_d = cfg_q;
    wr_lut_a = 1'b0;
    wr_lut_b = 1'b0;
    wr_lut_h = 1'b0;
    rdata_d = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CFG: cfg_d = reg_wdata[CFG_W-1:0];
        OFS_LUT_A: wr_lut_a = 1'b1;
        OFS_LUT_B: wr_lut_b = 1'b1;
        OFS_LUT_H: wr_lut_h = 1'b1;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CFG: rdata_d[CFG_W-1:0] = cfg_q;
        OFS_LUT_A: rdata_d[TAB4-1:0] = tab_a;
        OFS_LUT_B: rdata_d[TAB4-1:0] = tab_b;
        OFS_LUT_H: rdata_d[TAB3-1:0] = tab_h;
        OFS_STAT: rdata_d[ST_W-1:0] = {y_q, x_q, q_q[1], q_q[0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
      rdata_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // control steering: any general input to any internal control
  logic gate_int, pc_int, din_int, h1_int;
  logic [LUT_THREE_IN-1:0] h_addr;

  always_comb begin
    gate_int = ctl_s[cfg_q[B_CSEL_GATE +: SEL_W]];
    pc_int = ctl_s[cfg_q[B_CSEL_PC +: SEL_W]];
    din_int = ctl_s[cfg_q[B_CSEL_DIN +: SEL_W]];
    h1_int = ctl_s[cfg_q[B_CSEL_H1 +: SEL_W]];
    h_addr = {din_int, h1_int, pc_int};
  end

  lcs_lut #(.IN_W(LUT_FOUR_IN)) u_lut_a (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(wr_lut_a),
    .wr_table(reg_wdata[TAB4-1:0]),
    .addr(fa_s),
    .table_out(tab_a),
    .out_q(lut_a_q)
  );

  lcs_lut #(.IN_W(LUT_FOUR_IN)) u_lut_b (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(wr_lut_b),
    .wr_table(reg_wdata[TAB4-1:0]),
    .addr(gb_s),
    .table_out(tab_b),
    .out_q(lut_b_q)
  );

  lcs_lut #(.IN_W(LUT_THREE_IN)) u_lut_h (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(wr_lut_h),
    .wr_table(reg_wdata[TAB3-1:0]),
    .addr(h_addr),
    .table_out(tab_h),
    .out_q(lut_h_q)
  );

  // combinational outputs, taken from the registered table outputs and registered again
  always_comb begin
    x_d = cfg_q[B_XSEL] ? lut_h_q : lut_a_q;
    y_d = cfg_q[B_YSEL] ? lut_h_q : lut_b_q;
  end

  // the two storage elements
  logic [1:0] d_sel, eclk, rise, gate_eff, pc_eff, srval, latch_m;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_store
      always_comb begin
        unique case (lcs_dsrc_t'(cfg_q[B_DSEL + SEL_W*i +: SEL_W]))
          LCS_SRC_A: d_sel[i] = lut_a_q;
          LCS_SRC_B: d_sel[i] = lut_b_q;
          LCS_SRC_H: d_sel[i] = lut_h_q;
          LCS_SRC_DIN: d_sel[i] = din_int;
        endcase
        eclk[i] = clk_s ^ cfg_q[B_INV + i];
        rise[i] = eclk[i] & ~(clk_prev_q ^ cfg_q[B_INV + i]);
        gate_eff[i] = ~cfg_q[B_GATE_USE + i] | gate_int;
        pc_eff[i] = cfg_q[B_SR_USE + i] & pc_int;
        srval[i] = cfg_q[B_SRVAL + i];
        latch_m[i] = cfg_q[B_LATCH + i];
        if (init_s || pc_eff[i]) begin
          q_d[i] = srval[i];
        end else if (latch_m[i]) begin
          q_d[i] = (!eclk[i] && gate_eff[i]) ? d_sel[i] : q_q[i];
        end else begin
          q_d[i] = (rise[i] && gate_eff[i]) ? d_sel[i] : q_q[i];
        end
      end

      pc_ovr_a: assert property (pc_eff[i] && !init_s |=> q_q[i] == $past(srval[i]))
        else $error("preset/clear did not force the flop");
      init_force_a: assert property (init_s |=> q_q[i] == $past(srval[i]))
        else $error("global init did not force the flop");
      edge_cap_a: assert property (!latch_m[i] && rise[i] && gate_eff[i] && !pc_eff[i] && !init_s
          |=> q_q[i] == $past(d_sel[i]))
        else $error("flop missed capture on active edge");
      gate_hold_a: assert property (!latch_m[i] && !(rise[i] && gate_eff[i]) && !pc_eff[i] && !init_s
          |=> $stable(q_q[i]))
        else $error("flop changed without enabled edge");
      latch_open_a: assert property (latch_m[i] && !eclk[i] && gate_eff[i] && !pc_eff[i] && !init_s
          |=> q_q[i] == $past(d_sel[i]))
        else $error("open latch did not follow data");
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_q <= 2'h0;
      x_q <= 1'b0;
      y_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end else begin
      q_q <= q_d;
      x_q <= x_d;
      y_q <= y_d;
      clk_prev_q <= clk_s;
    end
  end

  x_sel_a: assert property (!cfg_q[B_XSEL] |=> comb_x == $past(lut_a_q))
    else $error("x output not from table a");
  y_sel_a: assert property (cfg_q[B_YSEL] |=> comb_y == $past(lut_h_q))
    else $error("y output not from three-input table");
  ctl_path_a: assert property (($stable(general_control_inputs) && $stable(cfg_q)) [*4]
      |-> pc_int == general_control_inputs[cfg_q[B_CSEL_PC +: SEL_W]])
    else $error("preset/clear not steered from selected input");

  assign reg_rdata = rdata_q;
  assign cell_q0 = q_q[0];
  assign cell_q1 = q_q[1];
  assign comb_x = x_q;
  assign comb_y = y_q;
endmodule

//--- rtl/lcs_pkg.sv
// constants for the logic cell storage pair
package lcs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LUT_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LUT_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LUT_H = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
  localparam int unsigned LUT_FOUR_IN = 4;
  localparam int unsigned LUT_THREE_IN = 3;
  localparam int unsigned CTL_N = 4;
  localparam int unsigned SEL_W = 2;
  // configuration word layout
  localparam int unsigned B_INV = 0;
  localparam int unsigned B_LATCH = 2;
  localparam int unsigned B_SRVAL = 4;
  localparam int unsigned B_GATE_USE = 6;
  localparam int unsigned B_SR_USE = 8;
  localparam int unsigned B_DSEL = 10;
  localparam int unsigned B_XSEL = 14;
  localparam int unsigned B_YSEL = 15;
  localparam int unsigned B_CSEL_GATE = 16;
  localparam int unsigned B_CSEL_PC = 18;
  localparam int unsigned B_CSEL_DIN = 20;
  localparam int unsigned B_CSEL_H1 = 22;
  localparam int unsigned CFG_W = 24;
  localparam logic [CFG_W-1:0] CFG_RST = 24'h000000;
  // status word layout
  localparam int unsigned ST_Q0 = 0;
  localparam int unsigned ST_Q1 = 1;
  localparam int unsigned ST_X = 2;
  localparam int unsigned ST_Y = 3;
  localparam int unsigned ST_W = 4;
  // synchroniser lanes
  localparam int unsigned SY_CTL = 0;
  localparam int unsigned SY_FA = 4;
  localparam int unsigned SY_GB = 8;
  localparam int unsigned SY_CLK = 12;
  localparam int unsigned SY_INIT = 13;
  localparam int unsigned SYNC_W = 14;
  typedef enum logic [1:0] {
    LCS_SRC_A = 2'h0,
    LCS_SRC_B = 2'h1,
    LCS_SRC_H = 2'h2,
    LCS_SRC_DIN = 2'h3
  } lcs_dsrc_t;
endpackage

//--- rtl/lcs_lut.sv
// lookup table with loadable contents and registered output
`timescale 1ns/10ps
module lcs_lut #(
  parameter int unsigned IN_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [(2**IN_W)-1:0] wr_table,
  input wire logic [IN_W-1:0] addr,
  output logic [(2**IN_W)-1:0] table_out,
  output logic out_q
);
  import lcs_pkg::*;

  localparam int unsigned ENT = 2**IN_W;

  generate
    if (IN_W < 1 || IN_W > LUT_FOUR_IN) begin : g_chk
      $error("lcs_lut: IN_W out of range");
    end
  endgenerate

  logic [ENT-1:0] table_q, table_d;
  logic out_d;

  always_comb begin
    table_d = wr_en ? wr_table : table_q;
    out_d = table_q[addr];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      table_q <= '0;
      out_q <= 1'b0;
    end else begin
      table_q <= table_d;
      out_q <= out_d;
    end
  end

  assign table_out = table_q;
endmodule

//--- verification/lcs_fabric_model.sv
// fabric side model: routes the control lines and makes the storage clock
`timescale 1ns/10ps
module lcs_fabric_model #(
  parameter int unsigned LAG = 4
) (
  input wire logic sys_clk,
  input wire logic clk_req,
  input wire logic [3:0] ctl_set,
  output logic storage_clock,
  output logic [3:0] general_control_inputs
);
  logic [LAG-1:0] lag_q = '0;
  initial storage_clock = 1'b0;
  initial general_control_inputs = 4'h0;
  // clock edge trails control changes so data has settled first
  always @(posedge sys_clk) begin
    general_control_inputs <= ctl_set;
    lag_q <= {lag_q[LAG-2:0], clk_req};
    storage_clock <= lag_q[LAG-1];
  end
endmodule

//--- verification/lcs_storage_pair_test.sv
// self-checking bench for the logic cell storage pair
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module lcs_storage_pair_test;
  import lcs_pkg::*;
  localparam logic [DATA_W-1:0] BASE = (32'h2 << B_CSEL_DIN) | (32'h3 << B_DSEL);
  logic sys_clk, rst_b, reg_wr, reg_rd, sreq, init, cx, cy, q0, q1, sclk;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [3:0] ctl, gci, la, lb;
  int n_errors = 0;
  int tests_run = 0;
  int cb[3] = '{1, 3, 2};
  lcs_storage_pair u_lcs_storage_pair (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .storage_clock(sclk), .global_init_pulse(init), .general_control_inputs(gci),
    .lut_four_a_in(la), .lut_four_b_in(lb), .cell_q0(q0), .cell_q1(q1), .comb_x(cx), .comb_y(cy));
  lcs_fabric_model u_lcs_fabric_model (.sys_clk(sys_clk), .clk_req(sreq), .ctl_set(ctl),
    .storage_clock(sclk), .general_control_inputs(gci));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic results();
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask
  // waits out synchroniser and model lag, checks {y, x, q1, q0}
  task automatic st(input logic [3:0] e);
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({cy, cx, q1, q0}, e)
    @(posedge sys_clk);
  endtask
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    sreq = 1'b0; init = 1'b0; ctl = 4'h0; la = 4'h0; lb = 4'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(OFS_CFG, 32'h0);
    rdc(OFS_STAT, 32'h0);
    wr(OFS_LUT_A, 32'hFFFF8000);
    rdc(OFS_LUT_A, 32'h00008000);
    rdc(8'h20, 32'h0);
    wr(OFS_LUT_B, 32'h0000A5C2);
    rdc(OFS_LUT_B, 32'h0000A5C2);
    wr(OFS_CFG, BASE);
    la <= 4'hF;
    ctl <= 4'h4;
    sreq <= 1'b1;
    st(4'b0111);
    sreq <= 1'b0;
    st(4'b0111);
    rdc(OFS_STAT, 32'h7);
    wr(OFS_STAT, 32'hFFFFFFFF);
    rdc(OFS_STAT, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CFG, (32'h3 << B_DSEL) | (i << B_CSEL_DIN));
      ctl <= 4'h1 << i;
      sreq <= 1'b1;
      st(4'b0111);
      sreq <= 1'b0;
      ctl <= ~(4'h1 << i);
      st(4'b0111);
      sreq <= 1'b1;
      st(4'b0110);
      sreq <= 1'b0;
      st(4'b0110);
    end
    wr(OFS_CFG, BASE | (32'h2 << B_INV));
    la <= 4'h0;
    ctl <= 4'h4;
    sreq <= 1'b1;
    st(4'b0011);
    sreq <= 1'b0;
    st(4'b0001);
    wr(OFS_CFG, BASE | (32'h3 << B_GATE_USE));
    ctl <= 4'h0;
    sreq <= 1'b1;
    st(4'b0001);
    sreq <= 1'b0;
    ctl <= 4'h1;
    st(4'b0001);
    sreq <= 1'b1;
    st(4'b0000);
    ctl <= 4'h5;
    st(4'b0000);
    sreq <= 1'b0;
    st(4'b0000);
    wr(OFS_CFG, BASE);
    ctl <= 4'h4;
    sreq <= 1'b1;
    st(4'b0001);
    sreq <= 1'b0;
    st(4'b0001);
    // latch mode: transparent while clock low, holds while high
    wr(OFS_CFG, BASE | (32'h3 << B_LATCH));
    ctl <= 4'h0;
    st(4'b0000);
    sreq <= 1'b1;
    st(4'b0000);
    ctl <= 4'h4;
    st(4'b0000);
    sreq <= 1'b0;
    st(4'b0001);
    wr(OFS_CFG, BASE | (32'h3 << B_SR_USE) | (32'h2 << B_SRVAL) | (32'h1 << B_CSEL_PC));
    ctl <= 4'h2;
    st(4'b0010);
    ctl <= 4'h6;
    sreq <= 1'b1;
    st(4'b0010);
    sreq <= 1'b0;
    st(4'b0010);
    wr(OFS_CFG, BASE | (32'h1 << B_SR_USE) | (32'h2 << B_SRVAL) | (32'h1 << B_CSEL_PC));
    sreq <= 1'b1;
    st(4'b0000);
    sreq <= 1'b0;
    st(4'b0000);
    init <= 1'b1;
    st(4'b0010);
    init <= 1'b0;
    wr(OFS_CFG, (32'h3 << B_CSEL_H1) | (32'h1 << B_CSEL_PC) | (32'h2 << B_CSEL_DIN) |
      (32'h1 << B_XSEL) | (32'h1 << B_YSEL));
    for (int k = 0; k < 3; k++) begin
      wr(OFS_LUT_H, 32'h1 << (1 << k));
      rdc(OFS_LUT_H, 32'h1 << (1 << k));
      ctl <= 4'h1 << cb[k];
      st(4'b1110);
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    results();
  end
endmodule
